/* File: csr_pkg.sv */
// Package for the processor status register block: field positions, resets, operations
package csr_pkg;

    // Field positions inside the status byte
    localparam int BIT_INDIRECT_BANK_HI = 7;
    localparam int BIT_DIRECT_BANK_HI = 6;
    localparam int BIT_DIRECT_BANK_LO = 5;
    localparam int BIT_WATCHDOG_EXPIRY_N = 4;
    localparam int BIT_POWER_DOWN_N = 3;
    localparam int BIT_RESULT_NULL = 2;
    localparam int BIT_NIBBLE_OVERFLOW = 1;
    localparam int BIT_MSB_OVERFLOW = 0;

    // Value after power-on reset; the three flags are undefined, zero chosen
    localparam logic [7:0] STATUS_RESET = 8'h18;

    // Masks of the bit groups
    localparam logic [7:0] MASK_FLAGS = 8'h07;
    localparam logic [7:0] MASK_CAUSE = 8'h18;
    localparam logic [7:0] MASK_BANK = 8'hE0;

    // Data memory bank size in bytes
    localparam int BANK_BYTES = 128;

    // Operations presented by the execution core
    typedef enum logic [3:0] {
        CSR_OP_NONE,
        CSR_OP_ADD_W_FILE,
        CSR_OP_ADD_LITERAL,
        CSR_OP_SUB_LITERAL,
        CSR_OP_SUB_W_FILE,
        CSR_OP_ROTATE_RIGHT,
        CSR_OP_ROTATE_LEFT,
        CSR_OP_LOGIC,
        CSR_OP_CLEAR_FILE,
        CSR_OP_MOVE
    } csr_op_t;

    // One instruction as seen by this block
    typedef struct packed {
        logic valid;
        csr_op_t op;
        logic [7:0] operand_a;
        logic [7:0] operand_b;
        logic dest_status;
    } csr_instr_t;

endpackage : csr_pkg

/* File: csr_status_register.sv */
// Processor status register with ALU flag computation and write merging
`timescale 1ns/100ps
// Overview of operation
// - Status register writable like any file register
// - Flag-updating ops suppress explicit flag writes
// - Reset-cause bits ignore all instruction writes
// - Clear op on status clears banks; clear op always sets null flag
// - Subtract carries are inverted borrow indicators
// - Expiry bit set on power-up, kick, sleep
// - Expiry bit cleared on watchdog time-out
// - Nibble flag is carry out of bit 3
// - Msb flag is carry out of bit 7
// - Subtract adds two's complement of operand
// - Rotates load msb flag with shifted bit
module csr_status_register (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Instruction from the execution core
    input wire csr_pkg::csr_instr_t instr,
    // Write data when status is the destination
    input wire logic [7:0] write_data,
    // Events from watchdog and sleep logic
    input wire logic watchdog_kick,
    input wire logic sleep_exec,
    input wire logic watchdog_timeout,
    // ALU result
    output logic [7:0] alu_result,
    // Register contents and bank selects
    output logic [7:0] processor_status,
    output logic [1:0] direct_bank,
    output logic indirect_bank_hi
);

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] addend;
    logic is_arith;
    logic is_sub;
    logic is_rot;
    logic affects_null;
    logic affects_carry;
    logic next_null;
    logic next_nibble;
    logic next_msb;
    logic [7:0] next_result;
    logic [7:0] next_status;

    // Operation class decode
    always_comb begin
        is_sub = (instr.op == csr_pkg::CSR_OP_SUB_LITERAL) ||
                 (instr.op == csr_pkg::CSR_OP_SUB_W_FILE);
        is_arith = is_sub || (instr.op == csr_pkg::CSR_OP_ADD_W_FILE) ||
                   (instr.op == csr_pkg::CSR_OP_ADD_LITERAL);
        is_rot = (instr.op == csr_pkg::CSR_OP_ROTATE_RIGHT) ||
                 (instr.op == csr_pkg::CSR_OP_ROTATE_LEFT);
        affects_null = is_arith || (instr.op == csr_pkg::CSR_OP_LOGIC) ||
                       (instr.op == csr_pkg::CSR_OP_CLEAR_FILE);
        affects_carry = is_arith || is_rot;
    end

    // Subtraction uses the same adder: a + ~b + 1, so carries read as not-borrow
    always_comb begin
        addend = is_sub ? ~instr.operand_b : instr.operand_b;
        sum = {1'b0, instr.operand_a} + {1'b0, addend} + {8'h00, is_sub};
        low_sum = {1'b0, instr.operand_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
    end

    // Result and flag values computed by the ALU
    always_comb begin
        next_result = instr.operand_a;
        next_msb = processor_status[csr_pkg::BIT_MSB_OVERFLOW];
        next_nibble = processor_status[csr_pkg::BIT_NIBBLE_OVERFLOW];
        case (instr.op)
            csr_pkg::CSR_OP_ADD_W_FILE, csr_pkg::CSR_OP_ADD_LITERAL,
            csr_pkg::CSR_OP_SUB_LITERAL, csr_pkg::CSR_OP_SUB_W_FILE: begin
                next_result = sum[7:0];
                next_msb = sum[8];
                next_nibble = low_sum[4];
            end
            csr_pkg::CSR_OP_ROTATE_RIGHT: begin
                next_result = {processor_status[csr_pkg::BIT_MSB_OVERFLOW],
                               instr.operand_a[7:1]};
                next_msb = instr.operand_a[0];
            end
            csr_pkg::CSR_OP_ROTATE_LEFT: begin
                next_result = {instr.operand_a[6:0],
                               processor_status[csr_pkg::BIT_MSB_OVERFLOW]};
                next_msb = instr.operand_a[7];
            end
            csr_pkg::CSR_OP_CLEAR_FILE: begin
                next_result = 8'h00;
            end
            default: begin
                next_result = instr.operand_a;
            end
        endcase
        next_null = (next_result == 8'h00);
    end

    // Merge explicit write, ALU flags and reset-cause events
    always_comb begin
        next_status = processor_status;
        if (instr.valid && instr.dest_status) begin
            if (instr.op == csr_pkg::CSR_OP_CLEAR_FILE) begin
                // Only the bank bits take the zero; flags other than null stay
                next_status = processor_status & ~csr_pkg::MASK_BANK;
            end else if (affects_null || affects_carry) begin
                // A flag-updating op disables the write to all three flags
                next_status = (write_data & csr_pkg::MASK_BANK) |
                              (processor_status & ~csr_pkg::MASK_BANK);
            end else begin
                // Cause bits always keep their value on a write
                next_status = (write_data & ~csr_pkg::MASK_CAUSE) |
                              (processor_status & csr_pkg::MASK_CAUSE);
            end
        end
        if (instr.valid && affects_carry) begin
            // ALU flags override the explicit write to the same bits
            next_status[csr_pkg::BIT_MSB_OVERFLOW] = next_msb;
        end
        if (instr.valid && is_arith) begin
            next_status[csr_pkg::BIT_NIBBLE_OVERFLOW] = next_nibble;
        end
        if (instr.valid && affects_null) begin
            next_status[csr_pkg::BIT_RESULT_NULL] = next_null;
        end
        // Time-out wins over a kick in the same cycle so a reset cause is not lost
        if (watchdog_kick) begin
            next_status[csr_pkg::BIT_WATCHDOG_EXPIRY_N] = 1'b1;
            next_status[csr_pkg::BIT_POWER_DOWN_N] = 1'b1;
        end
        if (sleep_exec) begin
            next_status[csr_pkg::BIT_WATCHDOG_EXPIRY_N] = 1'b1;
            next_status[csr_pkg::BIT_POWER_DOWN_N] = 1'b0;
        end
        if (watchdog_timeout) begin
            next_status[csr_pkg::BIT_WATCHDOG_EXPIRY_N] = 1'b0;
        end
    end

    // Status register storage; power-on value sets both cause bits
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            processor_status <= csr_pkg::STATUS_RESET;
        end else begin
            processor_status <= next_status;
        end
    end

    // Registered ALU result so the data output comes from a flip-flop
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            alu_result <= 8'h00;
        end else if (instr.valid) begin
            alu_result <= next_result;
        end
    end

    // Bank selects read straight from the stored bits
    assign direct_bank = processor_status[csr_pkg::BIT_DIRECT_BANK_HI:
                                          csr_pkg::BIT_DIRECT_BANK_LO];
    assign indirect_bank_hi = processor_status[csr_pkg::BIT_INDIRECT_BANK_HI];

endmodule // csr_status_register

/* File: csr_status_properties.sv */
// Port checks of the status register
`timescale 1ns/100ps
module csr_status_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Core inputs
    input wire csr_pkg::csr_instr_t instr,
    input wire logic watchdog_kick,
    input wire logic sleep_exec,
    input wire logic watchdog_timeout,
    // Register
    input wire logic [7:0] processor_status
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // A valid instruction of one kind
    sequence op_is(csr_pkg::csr_op_t o);
        instr.valid && instr.op == o;
    endsequence
    expiry_clear_a: assert property (watchdog_timeout |=> !processor_status[4])
        else $error("expiry bit kept");
    sleep_mark_a: assert property (sleep_exec && !watchdog_timeout |=>
        processor_status[4:3] == 2'h2) else $error("sleep mark wrong");
    cause_hold_a: assert property (!(watchdog_kick | sleep_exec | watchdog_timeout) |=>
        $stable(processor_status[4:3])) else $error("cause bits moved");
    clear_file_a: assert property (
        op_is(csr_pkg::CSR_OP_CLEAR_FILE) ##0 instr.dest_status |=>
        processor_status[7:5] == 3'h0 && processor_status[2]) else $error("clear wrong");
    clear_keeps_a: assert property (op_is(csr_pkg::CSR_OP_CLEAR_FILE) |=>
        $stable(processor_status[1:0])) else $error("clear touched flags");
    rotr_flag_a: assert property (op_is(csr_pkg::CSR_OP_ROTATE_RIGHT) |=>
        processor_status[0] == $past(instr.operand_a[0])) else $error("right rotate flag");
    rotl_flag_a: assert property (op_is(csr_pkg::CSR_OP_ROTATE_LEFT) |=>
        processor_status[0] == $past(instr.operand_a[7])) else $error("left rotate flag");
    rotate_keep_a: assert property (op_is(csr_pkg::CSR_OP_ROTATE_LEFT) |=>
        $stable(processor_status[2:1])) else $error("rotate moved flags");
endmodule // csr_status_properties

/* File: csr_core_model.sv */
// Execution core model: one instruction per cycle from a random word
`timescale 1ns/100ps
module csr_core_model (
    // Random word
    input wire logic [31:0] rnd,
    // Instruction towards the register
    output csr_pkg::csr_instr_t instr,
    output logic [7:0] write_data
);
    // Logic ops have no result to predict, so status is altered by moves instead
    assign instr = {~(rnd[31] & rnd[30]), (rnd[3:0] == 4'h7 || rnd[3:0] > 4'h9) ? 4'h9 :
        rnd[3:0], rnd[11:4], rnd[19:12], rnd[20]};
    // Half the writes keep the upper bank bits clear, the rest still exercise them
    assign write_data = {rnd[28:27] & {2{rnd[29]}}, rnd[26:21]};
endmodule // csr_core_model

/* File: cpu_status_flag_register_bench.sv */
// Self-checking bench of the status register fed by a random core model
`timescale 1ns/100ps
module cpu_status_flag_register_bench;
    logic mclk = 1'h0, rst_b = 1'h0, watchdog_kick = 1'h0, sleep_exec = 1'h0;
    logic watchdog_timeout = 1'h0, indirect_bank_hi;
    logic [31:0] rnd = 32'h1FF010F1; // First taken: add 0F+01 into status, data 3F
    logic [15:0] lfsr = 16'h0041;
    logic [16:0] p;
    logic [7:0] exp_st = 8'h18, write_data, alu_result, processor_status;
    logic [1:0] direct_bank;
    csr_pkg::csr_instr_t instr;
    int n_errors = 0, n_compared = 0;
    // Core model and register
    csr_core_model u_csr_core_model (.rnd(rnd), .instr(instr), .write_data(write_data));
    csr_status_register u_csr_status_register (.mclk(mclk), .rst_b(rst_b), .instr(instr),
        .write_data(write_data), .watchdog_kick(watchdog_kick), .sleep_exec(sleep_exec),
        .watchdog_timeout(watchdog_timeout), .alu_result(alu_result),
        .processor_status(processor_status), .direct_bank(direct_bank),
        .indirect_bank_hi(indirect_bank_hi));
    // 10 ns clock
    always #5 mclk = ~mclk;
    // Stimulus shift register step
    function automatic logic [15:0] step(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Next status and result; bit 16 marks a defined result
    function automatic logic [16:0] predict(logic [7:0] s, csr_pkg::csr_instr_t i,
        logic [7:0] d, logic [2:0] e);
        logic m, f, c;
        logic [7:0] b;
        logic [8:0] r;
        m = i.op inside {csr_pkg::CSR_OP_SUB_LITERAL, csr_pkg::CSR_OP_SUB_W_FILE};
        f = i.valid && i.op != csr_pkg::CSR_OP_NONE && i.op < csr_pkg::CSR_OP_LOGIC;
        c = s[0];
        b = m ? ~i.operand_b : i.operand_b;
        r = {1'h0, i.operand_a} + {1'h0, b} + {8'h00, m};
        if (i.valid && i.dest_status && i.op != csr_pkg::CSR_OP_CLEAR_FILE)
            s = {d[7:5], s[4:3], f ? s[2:0] : d[2:0]};
        if (f && i.op < csr_pkg::CSR_OP_ROTATE_RIGHT)
            s[2:0] = {r[7:0] == 8'h00, i.operand_a[4] ^ b[4] ^ r[4], r[8]};
        if (f && i.op == csr_pkg::CSR_OP_ROTATE_RIGHT) {r[7:0], s[0]} = {c, i.operand_a};
        if (f && i.op == csr_pkg::CSR_OP_ROTATE_LEFT) {s[0], r[7:0]} = {i.operand_a, c};
        if (i.valid && i.op == csr_pkg::CSR_OP_CLEAR_FILE)
            s = {i.dest_status ? 3'h0 : s[7:5], s[4:3], 1'h1, s[1:0]};
        if (e[2]) s[4:3] = 2'h3;
        if (e[1]) s[4:3] = 2'h2;
        if (e[0]) s[4] = 1'h0;
        return {f, r[7:0], s};
    endfunction
    // Counted comparison
    task automatic check(logic [7:0] got, logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("%0d compared, %0d errors", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Add case, clear case, then random traffic with events and one mid-run reset
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'h1;
        for (int n = 0; n < 600; n++) begin
            @(posedge mclk);
            p = rst_b ? predict(exp_st, instr, write_data,
                {watchdog_kick, sleep_exec, watchdog_timeout}) : 17'h10018;
            exp_st = p[7:0];
            lfsr = step(step(lfsr));
            rnd <= (n == 0) ? 32'h00100008 : {lfsr, step(lfsr)};
            rst_b <= (n != 300);
            {watchdog_kick, sleep_exec, watchdog_timeout} <= lfsr[7:4] == 4'h0 ? lfsr[2:0] : 3'h0;
            @(negedge mclk);
            check(processor_status, p[7:0]);
            check({5'h00, indirect_bank_hi, direct_bank}, {5'h00, p[7:5]});
            if (p[16]) check(alu_result, p[15:8]);
        end
        $display("random run done");
        give_verdict();
    end
endmodule // cpu_status_flag_register_bench
// Port checks on the register
bind csr_status_register csr_status_properties u_csr_status_properties (.mclk(mclk),
    .rst_b(rst_b), .instr(instr), .watchdog_kick(watchdog_kick), .sleep_exec(sleep_exec),
    .watchdog_timeout(watchdog_timeout), .processor_status(processor_status));
